//--- hdl/tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Register byte addresses
`define CAP_CTRL_ADDR  12'h000
`define CAP_BUF_ADDR   12'h004
`define CMP_CTRL_ADDR  12'h008
`define CMP_PRI_ADDR   12'h00c
`define CMP_SEC_ADDR   12'h010
`define STAT_ADDR      12'h014
// Capture control fields
`define CAP_SIDL_BIT   13
`define CAP_TSEL_BIT   7
`define CAP_CPI_HI     6
`define CAP_CPI_LO     5
`define CAP_OVF_BIT    4
`define CAP_BNE_BIT    3
`define MODE_HI        2
`define MODE_LO        0
// Compare control fields
`define CMP_SIDL_BIT   13
`define CMP_FLT_BIT    4
`define CMP_TSEL_BIT   3
// Writable masks
`define CAP_WMASK      16'h20e7
`define CMP_WMASK      16'h200f
// Capture modes
`define CM_OFF         3'h0
`define CM_BOTH        3'h1
`define CM_FALL        3'h2
`define CM_RISE        3'h3
`define CM_RISE4       3'h4
`define CM_RISE16      3'h5
`define CM_UNUSED      3'h6
`define CM_WAKE        3'h7
// Compare modes
`define OM_OFF         3'h0
`define OM_SETHI       3'h1
`define OM_SETLO       3'h2
`define OM_TOGGLE      3'h3
`define OM_SINGLE      3'h4
`define OM_CONT        3'h5
`define OM_PWM         3'h6
`define OM_PWMF        3'h7
// Prescale terminal counts
`define PRE4_LAST      4'h3
`define PRE16_LAST     4'hf
`endif

//--- hdl/tcc_pkg.sv
package tcc_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {OC_IDLE, OC_WAIT1, OC_WAIT2, OC_DONE} oc_state_e;
endpackage

//--- hdl/cap_fifo_if.sv
`timescale 1ns/10ps
interface cap_fifo_if;
	logic           push;
	logic           pop;
	tcc_pkg::word_t wdata;
	tcc_pkg::word_t rdata;
	logic           full;
	logic           empty;
	modport owner (output push, output pop, output wdata, input rdata, input full, input empty);
	modport store (input push, input pop, input wdata, output rdata, output full, output empty);
endinterface

//--- hdl/cap_fifo.sv
`timescale 1ns/10ps
module cap_fifo #(
	parameter int DEPTH = 4
) (
	input wire logic      clk,
	input wire logic      rst_n,
	input wire logic      flush,
	cap_fifo_if.store     f
);
	localparam int AW = $clog2(DEPTH);
	tcc_pkg::word_t mem [DEPTH];
	logic [AW-1:0]  wp_r;
	logic [AW-1:0]  rp_r;
	logic [AW:0]    cnt_r;
	tcc_pkg::word_t rd_r;
	wire            do_push = f.push && !f.full;
	wire            do_pop  = f.pop && !f.empty;
	assign f.full  = (cnt_r == (AW+1)'(DEPTH));
	assign f.empty = (cnt_r == '0);
	assign f.rdata = rd_r;
	always_ff @(posedge clk) begin
		if (do_push)
			mem[wp_r] <= f.wdata;
	end
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			rd_r  <= '0;
		end else begin
			if (do_push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (do_pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
			rd_r  <= (cnt_r == '0) ? '0 : mem[rp_r];
		end
	end
endmodule

//--- hdl/tcc_top.sv
`timescale 1ns/10ps
`include "tcc_map.svh"
// Summary of operation
// - Capture side, but for the mode 111 wake event, freezes in idle when its stop-in-idle bit is set.
// - Capture stores timer B when timer-select is 1, else timer C.
// - Capture event reports after every 1 to 4 captures per field.
// - Read-only overflow flag set by hardware on overflow, cleared by hardware.
// - Buffer-not-empty flag reads 1 while any captured value is unread.
// - Modes 011/100/101 capture every 1st, 4th, 16th rising edge.
// - Mode 010 falling edges; 001 both edges, event on every capture.
// - Mode 111 gives rising-edge wake event only in sleep or idle.
// - Modes 000 and 110 keep capture off.
// - Compare uses timer C when its select is 1, else timer B.
// - Compare output changes on timer match with one or two values.
// - Mode 001 starts low, match drives high, event on rise.
// - Mode 010 starts high, match drives low, event on fall.
// - Mode 011 keeps level on entry, toggles on match, event both edges.
// - Mode 100 starts low, emits one pulse, event on its fall.
// - Mode 101 starts low, emits pulse train, event each fall.
// - Mode 110 PWM, starts 1 unless primary value is zero, no event.
// - Mode 111 PWM with fault; falling fault input raises event.
// - Fault flag set only in mode 111, cleared by a compare control write or when the mode is not 111.
// - Mode 000 disables compare and hands pin to port logic.
// - Compare side, but for mode 111 fault handling, halts in idle when its stop-in-idle bit is set.
// - Each capture stores the full 16-bit timer value.
// - Captures queue in a four-entry FIFO read in arrival order.
module tcc_top #(
	parameter int FIFO_DEPTH = 4
) (
	// System
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	// AHB-Lite slave
	input  wire logic        HSEL_I,
	input  wire logic [11:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// Power state and timers
	input  wire logic        CPU_IDLE_I,
	input  wire logic        CPU_SLEEP_I,
	input  wire logic [15:0] TIMER_B_COUNT_I,
	input  wire logic [15:0] TIMER_C_COUNT_I,
	// Pins
	input  wire logic        CAPTURE_INPUT_PIN_I,
	input  wire logic        FAULT_INPUT_PIN_I,
	input  wire logic        PORT_DATA_I,
	output logic             COMPARE_OUTPUT_PIN_O,
	// Events
	output logic             CAPTURE_EVENT_O,
	output logic             COMPARE_EVENT_O
);
	////////////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [11:0] addr_r;
	logic [15:0] cap_ctrl_r;
	logic [15:0] cmp_ctrl_r;
	logic [15:0] pri_r;
	logic [15:0] sec_r;
	wire         take     = HSEL_I && HREADY_I && HTRANS_I[1];
	wire         wr_cap   = wr_pend_r && (addr_r == `CAP_CTRL_ADDR);
	wire         wr_cmp   = wr_pend_r && (addr_r == `CMP_CTRL_ADDR);
	wire         wr_pri   = wr_pend_r && (addr_r == `CMP_PRI_ADDR);
	wire         wr_sec   = wr_pend_r && (addr_r == `CMP_SEC_ADDR);
	wire         rd_buf   = take && !HWRITE_I && (HADDR_I == `CAP_BUF_ADDR);
	wire [2:0]   cap_mode = cap_ctrl_r[`MODE_HI:`MODE_LO];
	wire [2:0]   cmp_mode = cmp_ctrl_r[`MODE_HI:`MODE_LO];
	logic        ovf_r;
	logic        flt_r;
	logic [31:0] rd_mux;
	cap_fifo_if  fif ();
	wire [15:0]  cap_view = {cap_ctrl_r[15:5], ovf_r, !fif.empty, cap_ctrl_r[2:0]};
	wire [15:0]  cmp_view = {cmp_ctrl_r[15:5], flt_r, cmp_ctrl_r[3:0]};
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = 1'b0;
	assign HRDATA_O    = rd_pend_r ? rd_mux : 32'h0;
	always_comb begin
		if (addr_r == `CAP_CTRL_ADDR)
			rd_mux = {16'h0, cap_view};
		else if (addr_r == `CAP_BUF_ADDR)
			rd_mux = {16'h0, fif.rdata};
		else if (addr_r == `CMP_CTRL_ADDR)
			rd_mux = {16'h0, cmp_view};
		else if (addr_r == `CMP_PRI_ADDR)
			rd_mux = {16'h0, pri_r};
		else if (addr_r == `CMP_SEC_ADDR)
			rd_mux = {16'h0, sec_r};
		else if (addr_r == `STAT_ADDR)
			rd_mux = {30'h0, flt_r, ovf_r};
		else
			rd_mux = 32'h0;
	end
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			wr_pend_r  <= 1'b0;
			rd_pend_r  <= 1'b0;
			addr_r     <= 12'h0;
			cap_ctrl_r <= 16'h0;
			cmp_ctrl_r <= 16'h0;
			pri_r      <= 16'h0;
			sec_r      <= 16'h0;
		end else begin
			wr_pend_r <= take && HWRITE_I;
			rd_pend_r <= take && !HWRITE_I;
			if (take)
				addr_r <= HADDR_I;
			if (wr_cap)
				cap_ctrl_r <= HWDATA_I[15:0] & `CAP_WMASK;
			if (wr_cmp)
				cmp_ctrl_r <= HWDATA_I[15:0] & `CMP_WMASK;
			if (wr_pri)
				pri_r <= HWDATA_I[15:0];
			if (wr_sec)
				sec_r <= HWDATA_I[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input capture
	logic       pin_d_r;
	logic [3:0] pre_r;
	logic [1:0] per_r;
	wire        cap_run  = !(CPU_IDLE_I && cap_ctrl_r[`CAP_SIDL_BIT]);
	wire        rise     = CAPTURE_INPUT_PIN_I && !pin_d_r;
	wire        fall     = !CAPTURE_INPUT_PIN_I && pin_d_r;
	wire [3:0]  pre_last = (cap_mode == `CM_RISE4) ? `PRE4_LAST : `PRE16_LAST;
	wire        pre_hit  = rise && (pre_r == pre_last);
	logic       cap_ev;
	always_comb begin
		if (!cap_run)
			cap_ev = 1'b0;
		else if (cap_mode == `CM_RISE)
			cap_ev = rise;
		else if (cap_mode == `CM_RISE4 || cap_mode == `CM_RISE16)
			cap_ev = pre_hit;
		else if (cap_mode == `CM_FALL)
			cap_ev = fall;
		else if (cap_mode == `CM_BOTH)
			cap_ev = rise || fall;
		else
			cap_ev = 1'b0;
	end
	wire        wake_ev  = (cap_mode == `CM_WAKE) && rise && (CPU_SLEEP_I || CPU_IDLE_I);
	wire        per_hit  = (cap_mode == `CM_BOTH) || (per_r == cap_ctrl_r[`CAP_CPI_HI:`CAP_CPI_LO]);
	wire        cap_off  = (cap_mode == `CM_OFF) || (cap_mode == `CM_UNUSED);
	assign fif.push  = cap_ev;
	assign fif.wdata = cap_ctrl_r[`CAP_TSEL_BIT] ? TIMER_B_COUNT_I : TIMER_C_COUNT_I;
	assign fif.pop   = rd_buf;
	cap_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
		.clk   (CLK_I),
		.rst_n (RESETN_I),
		.flush (cap_off),
		.f     (fif.store)
	);
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			pin_d_r         <= 1'b0;
			pre_r           <= 4'h0;
			per_r           <= 2'h0;
			ovf_r           <= 1'b0;
			CAPTURE_EVENT_O <= 1'b0;
		end else begin
			pin_d_r <= CAPTURE_INPUT_PIN_I;
			if (cap_off)
				pre_r <= 4'h0;
			else if (cap_run && rise)
				pre_r <= pre_hit ? 4'h0 : pre_r + 4'h1;
			if (cap_off)
				per_r <= 2'h0;
			else if (cap_ev)
				per_r <= per_hit ? 2'h0 : per_r + 2'h1;
			if (cap_ev && fif.full)
				ovf_r <= 1'b1;
			else if (cap_off || (rd_buf && !fif.full))
				ovf_r <= 1'b0;
			CAPTURE_EVENT_O <= (cap_ev && per_hit) || wake_ev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output compare
	tcc_pkg::oc_state_e st_r;
	logic        oc_r;
	logic        flt_d_r;
	wire         cmp_run = !(CPU_IDLE_I && cmp_ctrl_r[`CMP_SIDL_BIT]);
	wire [15:0]  tmr     = cmp_ctrl_r[`CMP_TSEL_BIT] ? TIMER_C_COUNT_I : TIMER_B_COUNT_I;
	wire         m_pri   = cmp_run && (tmr == pri_r);
	wire         m_sec   = cmp_run && (tmr == sec_r);
	wire         flt_fall = !FAULT_INPUT_PIN_I && flt_d_r;
	logic        oc_nxt;
	tcc_pkg::oc_state_e st_nxt;
	always_comb begin
		oc_nxt = oc_r;
		st_nxt = st_r;
		if (wr_cmp) begin
			st_nxt = tcc_pkg::OC_WAIT1;
			if (HWDATA_I[2:0] == `OM_SETLO)
				oc_nxt = 1'b1;
			else if (HWDATA_I[2:0] == `OM_PWM || HWDATA_I[2:0] == `OM_PWMF)
				oc_nxt = (pri_r != 16'h0);
			else if (HWDATA_I[2:0] != `OM_TOGGLE)
				oc_nxt = 1'b0;
		end else begin
			case (cmp_mode)
			`OM_SETHI: if (m_pri) oc_nxt = 1'b1;
			`OM_SETLO: if (m_pri) oc_nxt = 1'b0;
			`OM_TOGGLE: if (m_pri) oc_nxt = !oc_r;
			`OM_SINGLE, `OM_CONT: begin
				case (st_r)
				tcc_pkg::OC_WAIT1: if (m_pri) begin
					oc_nxt = 1'b1;
					st_nxt = tcc_pkg::OC_WAIT2;
				end
				tcc_pkg::OC_WAIT2: if (m_sec) begin
					oc_nxt = 1'b0;
					st_nxt = (cmp_mode == `OM_CONT) ? tcc_pkg::OC_WAIT1 : tcc_pkg::OC_DONE;
				end
				default: st_nxt = st_r;
				endcase
			end
			`OM_PWM, `OM_PWMF: begin
				if (flt_r)
					oc_nxt = 1'b0;
				else if (tmr == 16'h0 && cmp_run)
					oc_nxt = (pri_r != 16'h0);
				else if (m_pri)
					oc_nxt = 1'b0;
			end
			default: oc_nxt = oc_r;
			endcase
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			st_r            <= tcc_pkg::OC_IDLE;
			oc_r            <= 1'b0;
			flt_d_r         <= 1'b1;
			flt_r           <= 1'b0;
			COMPARE_EVENT_O <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			oc_r    <= oc_nxt;
			flt_d_r <= FAULT_INPUT_PIN_I;
			if (cmp_mode == `OM_PWMF && flt_fall)
				flt_r <= 1'b1;
			else if (wr_cmp || cmp_mode != `OM_PWMF)
				flt_r <= 1'b0;
			if (wr_cmp)
				COMPARE_EVENT_O <= 1'b0;
			else if (cmp_mode == `OM_SETHI)
				COMPARE_EVENT_O <= oc_nxt && !oc_r;
			else if (cmp_mode == `OM_TOGGLE)
				COMPARE_EVENT_O <= oc_nxt != oc_r;
			else if (cmp_mode == `OM_SETLO || cmp_mode == `OM_SINGLE || cmp_mode == `OM_CONT)
				COMPARE_EVENT_O <= !oc_nxt && oc_r;
			else if (cmp_mode == `OM_PWMF)
				COMPARE_EVENT_O <= flt_fall;
			else
				COMPARE_EVENT_O <= 1'b0;
		end
	end
	assign COMPARE_OUTPUT_PIN_O = (cmp_mode == `OM_OFF) ? PORT_DATA_I : oc_r;
endmodule

//--- test/pin_env.sv
`timescale 1ns/10ps
module pin_env (
	// Clock
	input  wire logic clk_i,
	// Pins toward the channel
	output logic      cap_pin_o,
	output logic      fault_pin_o
);
	initial begin
		cap_pin_o = 1'b0;
		fault_pin_o = 1'b1;
	end
	// Pulses held high three cycles, then low four cycles before the next
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk_i) cap_pin_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			cap_pin_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
	// Fault line pulled low for four cycles
	task automatic fault();
		@(posedge clk_i) fault_pin_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		fault_pin_o <= 1'b1;
		@(posedge clk_i);
	endtask
endmodule

//--- test/tcc_properties.sv
`timescale 1ns/10ps
`include "tcc_map.svh"
module tcc_checker (
	// System
	input wire logic        CLK_I,
	input wire logic        RESETN_I,
	// Bus
	input wire logic        HSEL_I,
	input wire logic [11:0] HADDR_I,
	input wire logic [1:0]  HTRANS_I,
	input wire logic        HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic        HREADY_I,
	input wire logic        HREADYOUT_O,
	input wire logic        HRESP_O,
	// Pins and events
	input wire logic        FAULT_INPUT_PIN_I,
	input wire logic        PORT_DATA_I,
	input wire logic        COMPARE_OUTPUT_PIN_O,
	input wire logic        CAPTURE_EVENT_O,
	input wire logic        COMPARE_EVENT_O
);
	logic        wr_r;
	logic [11:0] adr_r;
	logic [2:0]  cm_r;
	logic [2:0]  om_r;
	// Shadow of the two mode fields
	always_ff @(posedge CLK_I) begin
		wr_r <= RESETN_I & HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
		adr_r <= HADDR_I;
		if (!RESETN_I) begin
			cm_r <= 3'h0;
			om_r <= 3'h0;
		end else if (wr_r && adr_r == `CAP_CTRL_ADDR) begin
			cm_r <= HWDATA_I[2:0];
		end else if (wr_r && adr_r == `CMP_CTRL_ADDR) begin
			om_r <= HWDATA_I[2:0];
		end
	end
	////////////////////////////////////////
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence flt_seen;
		om_r == `OM_PWMF && $fell(FAULT_INPUT_PIN_I);
	endsequence
	sequence held_low;
		(!COMPARE_OUTPUT_PIN_O) [*8];
	endsequence
	bus_okay_a: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready or not okay");
	cap_off_a: assert property ((cm_r == `CM_OFF || cm_r == `CM_UNUSED) [*3] |-> !CAPTURE_EVENT_O)
		else $error("capture event while capture off");
	port_pass_a: assert property (om_r == `OM_OFF |-> COMPARE_OUTPUT_PIN_O == PORT_DATA_I)
		else $error("pin not port value in mode 0");
	sethi_start_a: assert property ($changed(om_r) && om_r == `OM_SETHI |-> ##[0:2] !COMPARE_OUTPUT_PIN_O)
		else $error("mode 1 did not start low");
	setlo_start_a: assert property ($changed(om_r) && om_r == `OM_SETLO |-> ##[0:2] COMPARE_OUTPUT_PIN_O)
		else $error("mode 2 did not start high");
	rise_evt_a: assert property (om_r == `OM_SETHI && $rose(COMPARE_OUTPUT_PIN_O) |-> ##[0:1] COMPARE_EVENT_O)
		else $error("no event on rise");
	fall_evt_a: assert property (om_r == `OM_SETLO && $past(om_r) == `OM_SETLO
		&& $fell(COMPARE_OUTPUT_PIN_O) |-> ##[0:1] COMPARE_EVENT_O) else $error("no event on fall");
	toggle_evt_a: assert property (om_r == `OM_TOGGLE && $past(om_r) == `OM_TOGGLE
		&& $changed(COMPARE_OUTPUT_PIN_O) |-> ##[0:1] COMPARE_EVENT_O) else $error("no event on toggle");
	pwm_quiet_a: assert property ((om_r == `OM_PWM) [*2] |-> !COMPARE_EVENT_O)
		else $error("event in plain pwm");
	fault_evt_a: assert property (flt_seen |-> ##[0:2] COMPARE_EVENT_O)
		else $error("no event on fault");
	fault_low_a: assert property (flt_seen |-> ##3 held_low)
		else $error("pin not held low after fault");
endmodule
bind tcc_top tcc_checker chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .FAULT_INPUT_PIN_I(FAULT_INPUT_PIN_I),
	.PORT_DATA_I(PORT_DATA_I), .COMPARE_OUTPUT_PIN_O(COMPARE_OUTPUT_PIN_O),
	.CAPTURE_EVENT_O(CAPTURE_EVENT_O), .COMPARE_EVENT_O(COMPARE_EVENT_O));

//--- test/timer_capture_compare_channel_tb_top.sv
`timescale 1ns/10ps
`include "tcc_map.svh"
module timer_capture_compare_channel_tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        idle = 1'b0;
	logic        sleep = 1'b0;
	logic        port = 1'b0;
	logic        run = 1'b0;
	logic [15:0] tmr_b = 16'h0;
	logic [15:0] tmr_c = 16'h0;
	logic        cap_pin;
	logic        flt_pin;
	logic [31:0] hrdata;
	logic        hready;
	logic        pin;
	logic        cap_evt;
	logic        cmp_evt;
	logic [31:0] q;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cap_ev = 0;
	int          cmp_ev = 0;
	logic [15:0] cctl[14] = '{16'h0003, 16'h0023, 16'h0043, 16'h0063, 16'h0004, 16'h0005, 16'h0002,
		16'h0061, 16'h0000, 16'h0006, 16'h0007, 16'h0007, 16'h2003, 16'h0003};
	int          cnp[14] = '{4, 4, 4, 4, 16, 16, 3, 2, 2, 2, 1, 1, 2, 2};
	int          cne[14] = '{4, 2, 1, 1, 4, 1, 3, 4, 0, 0, 0, 1, 0, 2};
	logic [1:0]  cps[14] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
	logic [15:0] octl[8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0009, 16'h2001, 16'h0006};
	logic [2:0]  oex[8] = '{3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2};
	int          one[8] = '{1, 1, 1, 1, 1, 0, 0, 0};
	tcc_top dut (.CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(), .CPU_IDLE_I(idle), .CPU_SLEEP_I(sleep), .TIMER_B_COUNT_I(tmr_b),
		.TIMER_C_COUNT_I(tmr_c), .CAPTURE_INPUT_PIN_I(cap_pin), .FAULT_INPUT_PIN_I(flt_pin),
		.PORT_DATA_I(port), .COMPARE_OUTPUT_PIN_O(pin), .CAPTURE_EVENT_O(cap_evt), .COMPARE_EVENT_O(cmp_evt));
	pin_env env (.clk_i(clk), .cap_pin_o(cap_pin), .fault_pin_o(flt_pin));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (run) begin
			tmr_b <= tmr_b + 16'h1;
		end
	end
	always @(negedge clk) begin
		cap_ev += int'(cap_evt === 1'b1);
		cmp_ev += int'(cmp_evt === 1'b1);
	end
	////////////////////////////////////////
	task automatic ck(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#(25 * 30000);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(0, `CAP_CTRL_ADDR, 32'h0);
		ck("cap ctrl reset", 32'h0, q);
		bus(1, `CAP_CTRL_ADDR, 32'hffff);
		bus(0, `CAP_CTRL_ADDR, 32'h0);
		ck("cap ctrl mask", 32'h20e7, q);
		bus(1, `CMP_CTRL_ADDR, 32'hffff);
		bus(0, `CMP_CTRL_ADDR, 32'h0);
		ck("cmp ctrl mask", 32'h200f, q);
		bus(1, 12'h020, 32'hffff);
		bus(0, 12'h020, 32'h0);
		ck("unmapped", 32'h0, q);
		bus(1, `CMP_CTRL_ADDR, 32'h0);
		bus(1, `CAP_CTRL_ADDR, 32'h0);
		bus(1, `CAP_CTRL_ADDR, 32'h83);
		for (int i = 0; i < 5; i++) begin
			tmr_b <= 16'h1000 + 16'(i);
			tmr_c <= 16'h2000 + 16'(i);
			env.pulse(1);
		end
		repeat (3) @(posedge clk);
		bus(0, `CAP_CTRL_ADDR, 32'h0);
		ck("full overflow", 32'h9b, q);
		for (int i = 0; i < 4; i++) begin
			bus(0, `CAP_BUF_ADDR, 32'h0);
			ck("capture value", 32'h1000 + 32'(i), q);
		end
		bus(0, `CAP_CTRL_ADDR, 32'h0);
		ck("drained", 32'h83, q);
		bus(1, `CAP_CTRL_ADDR, 32'h03);
		tmr_c <= 16'hc3a5;
		env.pulse(1);
		repeat (3) @(posedge clk);
		bus(0, `CAP_BUF_ADDR, 32'h0);
		ck("timer c value", 32'hc3a5, q);
		for (int i = 0; i < 14; i++) begin
			bus(1, `CAP_CTRL_ADDR, 32'h0);
			bus(1, `CAP_CTRL_ADDR, {16'h0, cctl[i]});
			idle <= cps[i][1];
			sleep <= cps[i][0];
			cap_ev = 0;
			env.pulse(cnp[i]);
			repeat (4) @(posedge clk);
			ck("capture events", 32'(cne[i]), 32'(cap_ev));
			idle <= 1'b0;
			sleep <= 1'b0;
		end
		bus(1, `CAP_CTRL_ADDR, 32'h0);
		bus(1, `CMP_PRI_ADDR, 32'h10);
		bus(1, `CMP_SEC_ADDR, 32'h20);
		tmr_c <= 16'h0100;
		for (int i = 0; i < 8; i++) begin
			tmr_b <= 16'h0;
			bus(1, `CMP_CTRL_ADDR, 32'h0);
			bus(1, `CMP_CTRL_ADDR, {16'h0, octl[i]});
			idle <= oex[i][2];
			repeat (3) @(posedge clk);
			cmp_ev = 0;
			@(negedge clk) ck("compare start", {31'h0, oex[i][1]}, {31'h0, pin});
			@(posedge clk) run <= 1'b1;
			repeat (48) @(posedge clk);
			run <= 1'b0;
			repeat (3) @(posedge clk);
			@(negedge clk) ck("compare end", {31'h0, oex[i][0]}, {31'h0, pin});
			ck("compare events", 32'(one[i]), 32'(cmp_ev));
			@(posedge clk) idle <= 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			bus(1, `CMP_CTRL_ADDR, 32'h0);
			bus(1, `CMP_CTRL_ADDR, 32'h4 + 32'(i));
			cmp_ev = 0;
			repeat (2) begin
				tmr_b <= 16'h0;
				@(posedge clk) run <= 1'b1;
				repeat (48) @(posedge clk);
				run <= 1'b0;
				@(posedge clk);
			end
			@(negedge clk) ck("pulse count", 32'(i + 1), 32'(cmp_ev));
			@(posedge clk);
		end
		bus(1, `CMP_CTRL_ADDR, 32'h0);
		port <= 1'b1;
		@(negedge clk) ck("port pass", 32'h1, {31'h0, pin});
		@(posedge clk) port <= 1'b0;
		bus(1, `CMP_CTRL_ADDR, 32'h7);
		cmp_ev = 0;
		env.fault();
		repeat (2) @(posedge clk);
		@(negedge clk) ck("fault pin", 32'h0, {31'h0, pin});
		ck("fault events", 32'h1, 32'(cmp_ev));
		@(posedge clk);
		bus(0, `CMP_CTRL_ADDR, 32'h0);
		ck("fault flag", 32'h17, q);
		bus(0, `STAT_ADDR, 32'h0);
		ck("status", 32'h2, q);
		bus(1, `CMP_CTRL_ADDR, 32'h7);
		bus(0, `CMP_CTRL_ADDR, 32'h0);
		ck("fault cleared", 32'h7, q);
		bus(1, `CMP_CTRL_ADDR, 32'h6);
		cmp_ev = 0;
		env.fault();
		repeat (2) @(posedge clk);
		@(negedge clk) ck("plain pwm pin", 32'h1, {31'h0, pin});
		ck("plain pwm events", 32'h0, 32'(cmp_ev));
		@(posedge clk);
		bus(0, `CMP_CTRL_ADDR, 32'h0);
		ck("plain pwm flag", 32'h6, q);
		end_of_test();
	end
endmodule
